// File: rtl/csb_core_regs.sv
// Core special function registers: bank select, accumulator, program
// counter low byte, table pointers and latch, status flags.
// Assumes the instruction decoder drives the strobes on clk, one per cycle.
//
// Overview of operation
// - Bank register: only bit zero, reset zero
// - Direct addressing bank zero; pointer one follows
// - ALU results land in accumulator when alu_to_accum, and always in alu_result
// - Low byte write jumps within page
// - Low byte write inserts one dummy cycle
// - Table pointers address program memory table
// - Table read latches high program byte
// - Status write keeps system flags intact
// - Timeout flag: set timeout, clear refresh/sleep
// - Powerdown flag: set sleep, clear refresh
// - Overflow: carry-in differs from carry-out
// - Zero flag reflects zero result
// - Half carry from low nibble
// - Carry: add carry, no borrow, rotates
// - Status not pushed on calls/interrupts
// - Bits 7:6 zero, system flags read-only
`timescale 1ns/10ps
`include "csb_defines.svh"

module csb_core_regs #(
    parameter int PC_WIDTH = `CSB_PC_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    // Special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Data memory address generation
    input wire logic mem_indirect_one,
    input wire logic [7:0] indirect_pointer_one,
    output logic mem_bank,
    // ALU operation
    input wire logic alu_go,
    input wire csb_pkg::csb_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic rot_left,
    input wire logic alu_to_accum,
    output logic [7:0] alu_result_holder,
    output logic [7:0] alu_result,
    // Program counter
    input wire logic pc_step,
    input wire logic [PC_WIDTH-1:0] pc_load_value,
    input wire logic pc_load,
    output logic [PC_WIDTH-1:0] pc_value,
    output logic dummy_cycle,
    // Table read
    input wire logic table_read_done,
    input wire logic [15:0] table_word,
    output logic [15:0] table_addr,
    output logic [7:0] table_low_byte,
    // System events
    input wire logic watchdog_timeout,
    input wire logic watchdog_refresh_instr,
    input wire logic sleep_instr,
    // Flag view
    output logic [7:0] core_flags
);
    import csb_pkg::*;

    logic bank_select_bit;
    logic [7:0] accum_reg;
    logic [PC_WIDTH-1:0] pc_reg;
    logic [7:0] table_ptr_low;
    logic [7:0] table_ptr_high;
    logic [7:0] table_high_latch;
    logic watchdog_timeout_flag;
    logic powerdown_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    csb_state_t state_reg;
    logic [7:0] res_next;
    logic c_next;
    logic h_next;
    logic v_next;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] sum8;
    logic [7:0] rdata_next;
    logic wr_pc_low;
    logic flags_wr;

    // ----------------------------------------
    // ALU evaluation
    // ----------------------------------------
    always_comb
    begin
        sum9 = 9'h000;
        sum5 = 5'h00;
        sum8 = 8'h00;
        res_next = alu_a;
        c_next = carry_flag;
        h_next = half_carry_flag;
        v_next = signed_wrap_flag;
        case (alu_op)
            CSB_OP_ADD:
            begin
                sum9 = {1'b0, alu_a} + {1'b0, alu_b};
                sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
                sum8 = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]};
                res_next = sum9[7:0];
                c_next = sum9[8];
                h_next = sum5[4];
                v_next = sum8[7] ^ sum9[8];
            end
            CSB_OP_SUB:
            begin
                // Subtract as a + ~b + 1: carry out means no borrow
                sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
                sum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
                sum8 = {1'b0, alu_a[6:0]} + {1'b0, ~alu_b[6:0]} + 8'h01;
                res_next = sum9[7:0];
                c_next = sum9[8];
                h_next = sum5[4];
                v_next = sum8[7] ^ sum9[8];
            end
            CSB_OP_LOGIC:
            begin
                res_next = alu_a & alu_b;
            end
            CSB_OP_ROT:
            begin
                if (rot_left)
                begin
                    res_next = {alu_a[6:0], carry_flag};
                    c_next = alu_a[7];
                end
                else
                begin
                    res_next = {carry_flag, alu_a[7:1]};
                    c_next = alu_a[0];
                end
            end
            default:
            begin
                res_next = alu_a;
            end
        endcase
    end

    assign wr_pc_low = sfr_wr && (sfr_addr == `CSB_ADDR_PCLOW);
    assign flags_wr = sfr_wr && (sfr_addr == `CSB_ADDR_FLAGS);

    // ----------------------------------------
    // Bank select
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            bank_select_bit <= 1'(`CSB_RST_BANK);
        else if (clk_en && sfr_wr && sfr_addr == `CSB_ADDR_BANK)
            bank_select_bit <= sfr_wdata[0];
    end

    // Direct accesses never see bank one
    always_ff @(posedge clk)
    begin
        if (srst)
            mem_bank <= 1'b0;
        else if (clk_en)
            mem_bank <= mem_indirect_one & bank_select_bit;
    end

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    // Only ALU results or accumulator writes reach it; no reg-to-reg path
    always_ff @(posedge clk)
    begin
        if (srst)
            accum_reg <= 8'h00;
        else if (clk_en)
        begin
            if (alu_go && alu_to_accum)
                accum_reg <= res_next;
            else if (sfr_wr && sfr_addr == `CSB_ADDR_ACCUM)
                accum_reg <= sfr_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            alu_result <= 8'h00;
        else if (clk_en && alu_go)
            alu_result <= res_next;
    end

    // ----------------------------------------
    // Program counter and dummy cycle
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            pc_reg <= '0;
        else if (clk_en)
        begin
            if (wr_pc_low)
                pc_reg <= {pc_reg[PC_WIDTH-1:8], sfr_wdata};
            else if (pc_load)
                pc_reg <= pc_load_value;
            else if (pc_step && state_reg == CSB_ST_RUN)
                pc_reg <= pc_reg + PC_WIDTH'(1);
        end
    end

    // Fetch stalls one cycle after a low byte write
    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= CSB_ST_RUN;
        else if (clk_en)
        begin
            case (state_reg)
                CSB_ST_RUN:
                    if (wr_pc_low)
                        state_reg <= CSB_ST_DUMMY;
                CSB_ST_DUMMY:
                    if (!wr_pc_low)
                        state_reg <= CSB_ST_RUN;
                default:
                    state_reg <= CSB_ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Table pointers and latch
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            table_ptr_low <= 8'h00;
            table_ptr_high <= 8'h00;
        end
        else if (clk_en && sfr_wr)
        begin
            if (sfr_addr == `CSB_ADDR_TPLOW)
                table_ptr_low <= sfr_wdata;
            if (sfr_addr == `CSB_ADDR_TPHIGH)
                table_ptr_high <= sfr_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            table_high_latch <= 8'h00;
            table_low_byte <= 8'h00;
        end
        else if (clk_en && table_read_done)
        begin
            table_high_latch <= table_word[15:8];
            table_low_byte <= table_word[7:0];
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Data writes cannot reach the system flags
    always_ff @(posedge clk)
    begin
        if (srst)
            watchdog_timeout_flag <= 1'(`CSB_RST_SYSFLAGS >> 1);
        else if (clk_en)
        begin
            // Timeout wins over a same-cycle clear
            if (watchdog_timeout)
                watchdog_timeout_flag <= 1'b1;
            else if (watchdog_refresh_instr || sleep_instr)
                watchdog_timeout_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            powerdown_flag <= 1'(`CSB_RST_SYSFLAGS);
        else if (clk_en)
        begin
            if (sleep_instr)
                powerdown_flag <= 1'b1;
            else if (watchdog_refresh_instr)
                powerdown_flag <= 1'b0;
        end
    end

    // Arithmetic flags undefined at power-on; zero chosen for determinism.
    // No push on call or interrupt: software saves this byte itself.
    always_ff @(posedge clk)
    begin
        if (srst)
            {signed_wrap_flag, zero_flag, half_carry_flag, carry_flag} <= `CSB_RST_ARITH;
        else if (clk_en)
        begin
            if (flags_wr)
                {signed_wrap_flag, zero_flag, half_carry_flag, carry_flag} <=
                    sfr_wdata[3:0];
            else if (alu_go && alu_op != CSB_OP_NONE && alu_op != CSB_OP_MOVE)
            begin
                zero_flag <= (res_next == 8'h00);
                carry_flag <= c_next;
                half_carry_flag <= h_next;
                signed_wrap_flag <= v_next;
            end
        end
    end

    // ----------------------------------------
    // Read data and registered outputs
    // ----------------------------------------
    always_comb
    begin
        case (sfr_addr)
            `CSB_ADDR_BANK: rdata_next = {7'h00, bank_select_bit};
            `CSB_ADDR_ACCUM: rdata_next = accum_reg;
            `CSB_ADDR_PCLOW: rdata_next = pc_reg[7:0];
            `CSB_ADDR_TPLOW: rdata_next = table_ptr_low;
            `CSB_ADDR_THLATCH: rdata_next = table_high_latch;
            `CSB_ADDR_TPHIGH: rdata_next = table_ptr_high;
            `CSB_ADDR_FLAGS: rdata_next = {2'b00, watchdog_timeout_flag, powerdown_flag,
                signed_wrap_flag, zero_flag, half_carry_flag, carry_flag};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sfr_rdata <= 8'h00;
            alu_result_holder <= 8'h00;
            pc_value <= '0;
            dummy_cycle <= 1'b0;
            table_addr <= 16'h0000;
            core_flags <= 8'h00;
        end
        else if (clk_en)
        begin
            sfr_rdata <= rdata_next;
            alu_result_holder <= accum_reg;
            pc_value <= pc_reg;
            dummy_cycle <= wr_pc_low;
            table_addr <= {table_ptr_high, table_ptr_low};
            core_flags <= {2'b00, watchdog_timeout_flag, powerdown_flag,
                signed_wrap_flag, zero_flag, half_carry_flag, carry_flag};
        end
    end

endmodule : csb_core_regs

// File: rtl/csb_defines.svh
// Special function register constants for the core status bank.
// Assumes inclusion by the register file module, checker and bench, not by csb_pkg.sv.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

// ----------------------------------------
// Register addresses (special function area)
// ----------------------------------------
`define CSB_ADDR_BANK 8'h04
`define CSB_ADDR_ACCUM 8'h05
`define CSB_ADDR_PCLOW 8'h06
`define CSB_ADDR_TPLOW 8'h07
`define CSB_ADDR_THLATCH 8'h08
`define CSB_ADDR_FLAGS 8'h0A
`define CSB_ADDR_TPHIGH 8'h0C

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define CSB_BIT_CARRY 0
`define CSB_BIT_HALF 1
`define CSB_BIT_ZERO 2
`define CSB_BIT_WRAP 3
`define CSB_BIT_PDOWN 4
`define CSB_BIT_WDTO 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSB_RST_BANK 8'h00
`define CSB_RST_SYSFLAGS 2'b00
`define CSB_RST_ARITH 4'h0
`define CSB_PC_WIDTH 13
`define CSB_DUMMY_CYCLES 1

`endif

// File: rtl/csb_pkg.sv
// Types shared by the core status bank register file.
// Assumes csb_defines.svh on the include path.
package csb_pkg;

    // ----------------------------------------
    // ALU operation classes
    // ----------------------------------------
    typedef enum logic [2:0] {
        CSB_OP_NONE = 3'b000,
        CSB_OP_ADD = 3'b001,
        CSB_OP_SUB = 3'b010,
        CSB_OP_LOGIC = 3'b011,
        CSB_OP_ROT = 3'b100,
        CSB_OP_MOVE = 3'b101
    } csb_op_t;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    typedef enum logic [0:0] {
        CSB_ST_RUN = 1'b0,
        CSB_ST_DUMMY = 1'b1
    } csb_state_t;

endpackage : csb_pkg

// File: verif/csb_core_regs_asserts.sv
// Checker for the core status bank register file.
// Assumes it is bound to csb_core_regs and sees only its ports.
`timescale 1ns/10ps
`include "csb_defines.svh"

module csb_core_regs_chk #(
    parameter int PC_WIDTH = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    // Register access and address
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic mem_indirect_one,
    input wire logic mem_bank,
    // Program counter and flags
    input wire logic pc_load,
    input wire logic [PC_WIDTH-1:0] pc_value,
    input wire logic dummy_cycle,
    input wire logic watchdog_timeout,
    input wire logic watchdog_refresh_instr,
    input wire logic sleep_instr,
    input wire logic [7:0] core_flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence pc_low_write;
        clk_en && sfr_wr && sfr_addr == `CSB_ADDR_PCLOW;
    endsequence
    sequence quiet_follow;
        clk_en && !pc_load;
    endsequence

    a_flags_top: assert property (core_flags[7:6] == 2'b00)
        else $error("status top bits not zero");
    a_bank_direct: assert property ($past(clk_en) && !$past(mem_indirect_one) |-> !mem_bank)
        else $error("direct access left bank zero");
    a_lowbyte_dummy: assert property (pc_low_write |=> dummy_cycle)
        else $error("no dummy cycle after low byte write");
    a_dummy_cause: assert property ($rose(dummy_cycle) |->
        $past(clk_en && sfr_wr && sfr_addr == `CSB_ADDR_PCLOW))
        else $error("dummy cycle without low byte write");
    a_lowbyte_page: assert property (pc_low_write ##1 quiet_follow |=>
        pc_value[7:0] == $past(sfr_wdata, 2) && (pc_value >> 8) == ($past(pc_value) >> 8))
        else $error("low byte jump wrong or left page");
    // Reset guard: reset clears the flag view on the same edge as the flags
    a_wdto_rise: assert property ($rose(core_flags[5]) |->
        $past(watchdog_timeout) || $past(watchdog_timeout, 2))
        else $error("timeout flag set without timeout");
    a_wdto_fall: assert property ($fell(core_flags[5]) && !$past(srst) && !$past(srst, 2) |->
        $past(watchdog_refresh_instr || sleep_instr)
        || $past(watchdog_refresh_instr || sleep_instr, 2))
        else $error("timeout flag cleared without cause");
    a_pdown_rise: assert property ($rose(core_flags[4]) |->
        $past(sleep_instr) || $past(sleep_instr, 2))
        else $error("powerdown flag set without sleep");
    a_pdown_fall: assert property ($fell(core_flags[4]) && !$past(srst) && !$past(srst, 2) |->
        $past(watchdog_refresh_instr) || $past(watchdog_refresh_instr, 2))
        else $error("powerdown flag cleared without refresh");
endmodule : csb_core_regs_chk

bind csb_core_regs csb_core_regs_chk #(.PC_WIDTH(PC_WIDTH)) u_chk (.clk, .srst, .clk_en,
    .sfr_addr, .sfr_wr, .sfr_wdata, .mem_indirect_one, .mem_bank, .pc_load, .pc_value,
    .dummy_cycle, .watchdog_timeout, .watchdog_refresh_instr, .sleep_instr, .core_flags);

// File: verif/tb.sv
// Self-checking bench for the core status bank register file.
// Assumes design, package and checker compile first; one clock domain.
`timescale 1ns/10ps
`include "csb_defines.svh"

module tb;
    import csb_pkg::*;
    typedef struct packed {
        csb_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic rl;
        logic [7:0] res;
        logic [3:0] flg;
        logic [3:0] msk;
    } csb_row_t;
    // Rotates lean on the carry left by the row before
    csb_row_t rows [10] = '{
        '{CSB_OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80, 4'hA, 4'hF},
        '{CSB_OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 4'h7, 4'hF},
        '{CSB_OP_SUB, 8'h10, 8'h01, 1'b0, 8'h0F, 4'h1, 4'hF},
        '{CSB_OP_SUB, 8'h80, 8'h01, 1'b0, 8'h7F, 4'h9, 4'hF},
        '{CSB_OP_SUB, 8'h05, 8'h05, 1'b0, 8'h00, 4'h7, 4'hF},
        '{CSB_OP_LOGIC, 8'hF0, 8'h0F, 1'b0, 8'h00, 4'h4, 4'h4},
        '{CSB_OP_ADD, 8'h80, 8'h80, 1'b0, 8'h00, 4'hD, 4'hF},
        '{CSB_OP_ROT, 8'h81, 8'h00, 1'b1, 8'h03, 4'h1, 4'h1},
        '{CSB_OP_ROT, 8'h02, 8'h00, 1'b0, 8'h81, 4'h0, 4'h1},
        '{CSB_OP_MOVE, 8'h5A, 8'h00, 1'b0, 8'h5A, 4'h8, 4'hF}};
    logic clk, srst, clk_en, sfr_wr, mem_indirect_one, mem_bank, alu_go, rot_left;
    logic pc_step, pc_load, dummy_cycle, table_read_done, watchdog_timeout;
    logic watchdog_refresh_instr, sleep_instr;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, alu_a, alu_b, alu_result_holder;
    logic [7:0] alu_result, table_low_byte, core_flags;
    logic [12:0] pc_load_value, pc_value;
    logic [15:0] table_word, table_addr;
    csb_op_t alu_op;
    int error_cnt = 0;
    int checks_done = 0;

    csb_core_regs #(.PC_WIDTH(13)) dut (.clk, .srst, .clk_en, .sfr_addr, .sfr_wr,
        .sfr_wdata, .sfr_rdata, .mem_indirect_one, .indirect_pointer_one(8'h00), .mem_bank,
        .alu_go, .alu_op, .alu_a, .alu_b, .rot_left, .alu_to_accum(1'b1), .alu_result_holder,
        .alu_result, .pc_step, .pc_load_value, .pc_load, .pc_value, .dummy_cycle,
        .table_read_done, .table_word, .table_addr, .table_low_byte, .watchdog_timeout,
        .watchdog_refresh_instr, .sleep_instr, .core_flags);

    // ----------------------------------------
    // Tasks, all entered at a falling edge
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        sfr_addr = ad;
        tick(2);
        chk(sfr_rdata, e);
    endtask : rd
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask : pulse
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #40000;
        error_cnt++;
        test_done;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {srst, clk_en} = 2'b11;
        {sfr_wr, mem_indirect_one, alu_go, rot_left, pc_step, pc_load} = 6'h00;
        {table_read_done, watchdog_timeout, watchdog_refresh_instr, sleep_instr} = 4'h0;
        {sfr_addr, sfr_wdata, alu_a, alu_b} = 32'h0000_0000;
        {pc_load_value, table_word} = 29'h0000_0000;
        alu_op = CSB_OP_NONE;
        tick(5);
        srst = 1'b0;
        tick(1);
        chk(core_flags, 8'h00);
        rd(`CSB_ADDR_BANK, 8'h00);
        wr(`CSB_ADDR_BANK, 8'hFF);
        rd(`CSB_ADDR_BANK, 8'h01);
        mem_indirect_one = 1'b1;
        tick(2);
        chk(mem_bank, 1'b1);
        mem_indirect_one = 1'b0;
        tick(2);
        chk(mem_bank, 1'b0);
        foreach (rows[i])
        begin
            {alu_op, alu_a, alu_b, rot_left} = {rows[i].op, rows[i].a, rows[i].b, rows[i].rl};
            pulse(alu_go);
            chk(alu_result, rows[i].res);
            chk(alu_result_holder, rows[i].res);
            chk(core_flags[3:0] & rows[i].msk, rows[i].flg);
        end
        rd(`CSB_ADDR_ACCUM, 8'h5A);
        wr(`CSB_ADDR_FLAGS, 8'hFF);
        tick(2);
        chk(core_flags, 8'h0F);
        pulse(watchdog_timeout);
        wr(`CSB_ADDR_FLAGS, 8'h00);
        tick(2);
        chk(core_flags, 8'h20);
        pulse(sleep_instr);
        chk(core_flags, 8'h10);
        pulse(watchdog_timeout);
        chk(core_flags, 8'h30);
        rd(`CSB_ADDR_FLAGS, 8'h30);
        pulse(watchdog_refresh_instr);
        chk(core_flags, 8'h00);
        pc_load_value = 13'h1234;
        pulse(pc_load);
        wr(`CSB_ADDR_PCLOW, 8'h56);
        chk(dummy_cycle, 1'b1);
        tick(2);
        chk(pc_value, 13'h1256);
        pulse(pc_step);
        chk(pc_value, 13'h1257);
        rd(`CSB_ADDR_PCLOW, 8'h57);
        wr(`CSB_ADDR_TPLOW, 8'h34);
        // One idle edge so the strobe is not lowered and raised at once
        tick(1);
        wr(`CSB_ADDR_TPHIGH, 8'h12);
        tick(2);
        chk(table_addr, 16'h1234);
        rd(`CSB_ADDR_TPHIGH, 8'h12);
        table_word = 16'hABCD;
        pulse(table_read_done);
        chk(table_low_byte, 8'hCD);
        wr(`CSB_ADDR_THLATCH, 8'h00);
        rd(`CSB_ADDR_THLATCH, 8'hAB);
        // Frozen clock enable must swallow the operation
        clk_en = 1'b0;
        {alu_op, alu_a, alu_b} = {CSB_OP_ADD, 8'h11, 8'h22};
        pulse(alu_go);
        clk_en = 1'b1;
        tick(2);
        chk(alu_result, 8'h5A);
        pulse(watchdog_timeout);
        srst = 1'b1;
        tick(3);
        srst = 1'b0;
        tick(2);
        chk(core_flags, 8'h00);
        rd(`CSB_ADDR_BANK, 8'h00);
        test_done;
    end
endmodule : tb
